// ==== pkg/ssdp_pkg.sv ====
// constants for the step duty profile register bank
package ssdp_pkg;

  // ---------------------------------------------------------------
  // register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0]  TWO_PH_IDX        = 8'h96;
  localparam logic [7:0]  THREE_PH_IDX      = 8'h98;
  localparam logic [7:0]  STATUS_IDX        = 8'hc0;
  localparam logic [11:0] TWO_PH_ADDR       = {2'h0, TWO_PH_IDX, 2'h0};
  localparam logic [11:0] THREE_PH_ADDR     = {2'h0, THREE_PH_IDX, 2'h0};
  localparam logic [11:0] STATUS_ADDR       = {2'h0, STATUS_IDX, 2'h0};

  // ---------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [31:0] PROFILE_RESET     = 32'h0000_0000;
  localparam int          PARITY_BIT        = 31;
  localparam int          STEP0_MSB         = 30;
  localparam int          STEP_WIDTH        = 3;
  localparam int          NUM_STEPS         = 8;
  localparam int          ADV_LSB           = 5;
  localparam int          ADV_WIDTH         = 2;
  localparam int          TWO_RSVD_WIDTH    = 7;
  localparam logic [1:0]  HTRANS_NONSEQ_BIT = 2'h2;

  // ---------------------------------------------------------------
  // duty table in hundredths of a percent, and advance in degrees
  // ---------------------------------------------------------------
  localparam logic [13:0] DUTY_C0           = 14'h0000;
  localparam logic [13:0] DUTY_C1           = 14'h1388;
  localparam logic [13:0] DUTY_C2           = 14'h1d4c;
  localparam logic [13:0] DUTY_C3           = 14'h20b7;
  localparam logic [13:0] DUTY_C4           = 14'h222e;
  localparam logic [13:0] DUTY_C5           = 14'h249f;
  localparam logic [13:0] DUTY_C6           = 14'h2616;
  localparam logic [13:0] DUTY_C7           = 14'h26ac;
  localparam logic [3:0]  ADV_STEP_DEG      = 4'h5;

endpackage : ssdp_pkg

// ==== hdl/ssdp_regs.sv ====
// step duty profile register bank with ahb-lite slave and duty selection
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps

// Function
// - a read/write two-phase profile word sits at index 0x96 and resets to zero.
// - the two-phase word sets the duty of modulation steps where two phases conduct.
// - bit 31 of each profile word is a read/write parity bit resetting to zero.
// - two-phase step 0 duty is bits 30..28, codes 0..7 meaning 0/50/75/83.75/87.5/93.75/97.5/99 percent.
// - two-phase step 1 duty is bits 27..25 with the same code table.
// - two-phase step 2 duty is bits 24..22 with the same code table.
// - two-phase step 3 duty is bits 21..19 with the same code table.
// - two-phase step 4 duty is bits 18..16 with the same code table.
// - two-phase step 5 duty is bits 15..13 with the same code table.
// - two-phase step 6 duty is bits 12..10 with the same code table.
// - two-phase step 7 duty is bits 9..7 with the same code table.
// - bits 6..0 of the two-phase word are reserved read/write storage resetting to zero.
// - a read/write three-phase profile word sits at index 0x98 and resets to zero.
// - the three-phase word sets the duty of modulation steps where three phases conduct.
// - the three-phase word holds eight 3-bit step duties from bits 30..28 down to 9..7, same table.
// - bits 6..5 of the three-phase word pick an angle advance of 0, 5, 10 or 15 degrees.
module ssdp_regs (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // modulation step selection
  input  wire logic [2:0]  step_index,
  input  wire logic        three_phase_step,
  // applied duty
  output logic      [2:0]  step_duty_code,
  output logic      [13:0] step_duty_centipct,
  output logic      [3:0]  wide_mod_angle_advance,
  output logic      [31:0] two_phase_step_duty_profile,
  output logic      [31:0] three_phase_step_duty_profile
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // duty field of one step; step 0 at the top, eight fields downward
  function automatic logic [2:0] step_field(input logic [31:0] word, input logic [2:0] step);
    logic [4:0] lsb;
    lsb = 5'(ssdp_pkg::STEP0_MSB - ssdp_pkg::STEP_WIDTH + 1) - 5'({2'h0, step} * 5'h03);
    step_field = 3'(word >> lsb);
  endfunction : step_field

  function automatic logic [13:0] duty_of(input logic [2:0] code);
    logic [13:0] d;
    d = ssdp_pkg::DUTY_C0;
    unique case (code)
      3'h0: d = ssdp_pkg::DUTY_C0;
      3'h1: d = ssdp_pkg::DUTY_C1;
      3'h2: d = ssdp_pkg::DUTY_C2;
      3'h3: d = ssdp_pkg::DUTY_C3;
      3'h4: d = ssdp_pkg::DUTY_C4;
      3'h5: d = ssdp_pkg::DUTY_C5;
      3'h6: d = ssdp_pkg::DUTY_C6;
      3'h7: d = ssdp_pkg::DUTY_C7;
    endcase
    duty_of = d;
  endfunction : duty_of

  // ---------------------------------------------------------------
  // address phase capture
  // ---------------------------------------------------------------
  logic        wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic [31:0] two_ph_reg;
  logic [31:0] three_ph_reg;
  logic [31:0] rdata_next;
  logic [2:0]  code_next;
  logic        take;

  assign take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else if (hready) begin
      wr_pend_reg <= take && hwrite;
      wr_addr_reg <= {haddr[11:2], 2'h0};
    end
  end

  // zero wait state, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // profile registers, whole word read/write including parity and reserved bits
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      two_ph_reg <= ssdp_pkg::PROFILE_RESET;
    end else if (wr_pend_reg && wr_addr_reg == ssdp_pkg::TWO_PH_ADDR) begin
      two_ph_reg <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      three_ph_reg <= ssdp_pkg::PROFILE_RESET;
    end else if (wr_pend_reg && wr_addr_reg == ssdp_pkg::THREE_PH_ADDR) begin
      three_ph_reg <= hwdata;
    end
  end

  // ---------------------------------------------------------------
  // read data, with a write still in its data phase forwarded
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case ({haddr[11:2], 2'h0})
      ssdp_pkg::TWO_PH_ADDR:
        rdata_next = (wr_pend_reg && wr_addr_reg == ssdp_pkg::TWO_PH_ADDR) ? hwdata : two_ph_reg;
      ssdp_pkg::THREE_PH_ADDR:
        rdata_next = (wr_pend_reg && wr_addr_reg == ssdp_pkg::THREE_PH_ADDR) ? hwdata : three_ph_reg;
      ssdp_pkg::STATUS_ADDR:
        rdata_next = {8'h00, wide_mod_angle_advance, step_duty_code, step_duty_centipct, 3'h0};
      default:
        rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // per-step field views of both words
  // ---------------------------------------------------------------
  logic [2:0]  dual_conduct_duty_s0;
  logic [2:0]  dual_conduct_duty_s1;
  logic [2:0]  dual_conduct_duty_s2;
  logic [2:0]  dual_conduct_duty_s3;
  logic [2:0]  dual_conduct_duty_s4;
  logic [2:0]  dual_conduct_duty_s5;
  logic [2:0]  dual_conduct_duty_s6;
  logic [2:0]  dual_conduct_duty_s7;
  logic [2:0]  triple_conduct_duty_s0;
  logic [2:0]  triple_conduct_duty_s1;
  logic [2:0]  triple_conduct_duty_s2;
  logic [2:0]  triple_conduct_duty_s3;
  logic [2:0]  triple_conduct_duty_s4;
  logic [2:0]  triple_conduct_duty_s5;
  logic [2:0]  triple_conduct_duty_s6;
  logic [2:0]  triple_conduct_duty_s7;
  logic [1:0]  angle_code;
  logic [2:0]  two_code;
  logic [2:0]  three_code;

  assign dual_conduct_duty_s0   = step_field(two_ph_reg, 3'h0);
  assign dual_conduct_duty_s1   = step_field(two_ph_reg, 3'h1);
  assign dual_conduct_duty_s2   = step_field(two_ph_reg, 3'h2);
  assign dual_conduct_duty_s3   = step_field(two_ph_reg, 3'h3);
  assign dual_conduct_duty_s4   = step_field(two_ph_reg, 3'h4);
  assign dual_conduct_duty_s5   = step_field(two_ph_reg, 3'h5);
  assign dual_conduct_duty_s6   = step_field(two_ph_reg, 3'h6);
  assign dual_conduct_duty_s7   = step_field(two_ph_reg, 3'h7);
  assign triple_conduct_duty_s0 = step_field(three_ph_reg, 3'h0);
  assign triple_conduct_duty_s1 = step_field(three_ph_reg, 3'h1);
  assign triple_conduct_duty_s2 = step_field(three_ph_reg, 3'h2);
  assign triple_conduct_duty_s3 = step_field(three_ph_reg, 3'h3);
  assign triple_conduct_duty_s4 = step_field(three_ph_reg, 3'h4);
  assign triple_conduct_duty_s5 = step_field(three_ph_reg, 3'h5);
  assign triple_conduct_duty_s6 = step_field(three_ph_reg, 3'h6);
  assign triple_conduct_duty_s7 = step_field(three_ph_reg, 3'h7);
  assign angle_code             = three_ph_reg[ssdp_pkg::ADV_LSB +: ssdp_pkg::ADV_WIDTH];

  // ---------------------------------------------------------------
  // duty applied to the current step
  // ---------------------------------------------------------------
  // step field of the two-phase word
  always_comb begin
    two_code = 3'h0;
    unique case (step_index)
      3'h0: begin
        two_code = dual_conduct_duty_s0;
      end
      3'h1: begin
        two_code = dual_conduct_duty_s1;
      end
      3'h2: begin
        two_code = dual_conduct_duty_s2;
      end
      3'h3: begin
        two_code = dual_conduct_duty_s3;
      end
      3'h4: begin
        two_code = dual_conduct_duty_s4;
      end
      3'h5: begin
        two_code = dual_conduct_duty_s5;
      end
      3'h6: begin
        two_code = dual_conduct_duty_s6;
      end
      3'h7: begin
        two_code = dual_conduct_duty_s7;
      end
    endcase
  end

  // step field of the three-phase word
  always_comb begin
    three_code = 3'h0;
    unique case (step_index)
      3'h0: begin
        three_code = triple_conduct_duty_s0;
      end
      3'h1: begin
        three_code = triple_conduct_duty_s1;
      end
      3'h2: begin
        three_code = triple_conduct_duty_s2;
      end
      3'h3: begin
        three_code = triple_conduct_duty_s3;
      end
      3'h4: begin
        three_code = triple_conduct_duty_s4;
      end
      3'h5: begin
        three_code = triple_conduct_duty_s5;
      end
      3'h6: begin
        three_code = triple_conduct_duty_s6;
      end
      3'h7: begin
        three_code = triple_conduct_duty_s7;
      end
    endcase
  end

  // pick the word of the conduction kind
  always_comb begin
    if (three_phase_step) begin
      code_next = three_code;
    end else begin
      code_next = two_code;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_duty_code     <= 3'h0;
      step_duty_centipct <= 14'h0000;
    end else begin
      step_duty_code     <= code_next;
      step_duty_centipct <= duty_of(code_next);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wide_mod_angle_advance <= 4'h0;
    end else begin
      wide_mod_angle_advance <= 4'({2'h0, angle_code} * ssdp_pkg::ADV_STEP_DEG);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      two_phase_step_duty_profile   <= ssdp_pkg::PROFILE_RESET;
      three_phase_step_duty_profile <= ssdp_pkg::PROFILE_RESET;
    end else begin
      two_phase_step_duty_profile   <= two_ph_reg;
      three_phase_step_duty_profile <= three_ph_reg;
    end
  end

endmodule : ssdp_regs

// ==== bench/ssdp_checker.sv ====
// assertion checker for the step duty profile register bank
`timescale 1ns/10ps
module ssdp_checker (
  // clock, reset and bus
  input wire logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [31:0] haddr, hwdata, hrdata,
  input wire logic [1:0]  htrans,
  // step side
  input wire logic        three_phase_step,
  input wire logic [2:0]  step_index, step_duty_code,
  input wire logic [13:0] step_duty_centipct,
  input wire logic [3:0]  wide_mod_angle_advance,
  input wire logic [31:0] two_phase_step_duty_profile, three_phase_step_duty_profile
);
  localparam logic [13:0] TBL [8] = '{ssdp_pkg::DUTY_C0, ssdp_pkg::DUTY_C1, ssdp_pkg::DUTY_C2, ssdp_pkg::DUTY_C3,
    ssdp_pkg::DUTY_C4, ssdp_pkg::DUTY_C5, ssdp_pkg::DUTY_C6, ssdp_pkg::DUTY_C7};
  wire [31:0] p2 = two_phase_step_duty_profile;
  wire [31:0] p3 = three_phase_step_duty_profile;
  wire        tk = hsel && hready && htrans[1];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence wr_two; tk && hwrite && haddr[11:2] == ssdp_pkg::TWO_PH_ADDR[11:2] ##1 1'b1; endsequence
  sequence wr_three; tk && hwrite && haddr[11:2] == ssdp_pkg::THREE_PH_ADDR[11:2] ##1 1'b1; endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_no_wait: assert property ($past(hresetn) |-> hreadyout)
    else $error("wait state inserted");
  a_two_store: assert property (wr_two |=> ##1 p2 == $past(hwdata, 2))
    else $error("two-phase word not stored");
  a_three_store: assert property (wr_three |=> ##1 p3 == $past(hwdata, 2))
    else $error("three-phase word not stored");
  a_hole_zero: assert property (tk && !hwrite && haddr[11:2] == 10'h097 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_code_pick: assert property ($past(hresetn) |-> step_duty_code ==
    3'(($past(three_phase_step) ? p3 : p2) >> (5'd28 - 5'd3 * 5'($past(step_index)))))
    else $error("wrong step duty code");
  a_duty_map: assert property (step_duty_centipct == TBL[step_duty_code])
    else $error("wrong duty value");
  a_adv_deg: assert property ($past(hresetn) |-> wide_mod_angle_advance == 4'(p3[6:5]) * 4'h5)
    else $error("wrong angle advance");
endmodule : ssdp_checker
bind ssdp_regs ssdp_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata), .htrans(htrans),
  .three_phase_step(three_phase_step), .step_index(step_index), .step_duty_code(step_duty_code),
  .step_duty_centipct(step_duty_centipct), .wide_mod_angle_advance(wide_mod_angle_advance),
  .two_phase_step_duty_profile(two_phase_step_duty_profile),
  .three_phase_step_duty_profile(three_phase_step_duty_profile));

// ==== bench/test_ssdp_regs.sv ====
// self-checking testbench for the step duty profile register bank
`timescale 1ns/10ps
module test_ssdp_regs;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, three_phase_step = 0, rd_d = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, v, w, q[$];
  logic [1:0]  htrans = 0;
  logic [2:0]  step_index = 0, step_duty_code;
  logic        hreadyout, hresp;
  logic [3:0]  wide_mod_angle_advance;
  int          err_total = 0, n_checks = 0;
  localparam logic [13:0] TBL [8] = '{ssdp_pkg::DUTY_C0, ssdp_pkg::DUTY_C1, ssdp_pkg::DUTY_C2, ssdp_pkg::DUTY_C3,
    ssdp_pkg::DUTY_C4, ssdp_pkg::DUTY_C5, ssdp_pkg::DUTY_C6, ssdp_pkg::DUTY_C7};
  ssdp_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .step_index(step_index), .three_phase_step(three_phase_step), .step_duty_code(step_duty_code),
    .step_duty_centipct(), .wide_mod_angle_advance(wide_mod_angle_advance),
    .two_phase_step_duty_profile(), .three_phase_step_duty_profile());
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // single ahb transfer; a read notes its expected data for the monitor
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'h2; hsel <= 1'b1; haddr <= 32'(a); hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d; rd_d <= !wr;
    if (!wr) q.push_back(d);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_d <= 1'b0;
  endtask : bus
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  always @(posedge hclk) begin
    if (rd_d && hreadyout === 1'b1) check(hrdata, q.pop_front());
  end
  initial forever #5 hclk = ~hclk;
  initial begin
    #200000;
    err_total++;
    stop_test();
  end
  initial begin
    void'($urandom(78079));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, ssdp_pkg::TWO_PH_ADDR, 32'h0);
    bus(1'b0, ssdp_pkg::THREE_PH_ADDR, 32'h0);
    $display("reset values done");
    repeat (4) begin
      v = $urandom;
      w = $urandom;
      bus(1'b1, ssdp_pkg::TWO_PH_ADDR, v);
      bus(1'b1, ssdp_pkg::THREE_PH_ADDR, w);
      bus(1'b1, 12'h25c, ~w);
      bus(1'b0, 12'h25c, 32'h0);
      bus(1'b0, ssdp_pkg::TWO_PH_ADDR, v);
      bus(1'b0, ssdp_pkg::THREE_PH_ADDR, w);
      // every step of both words, checked once the pipeline has settled
      for (int s = 0; s < 16; s++) begin
        step_index <= 3'(s);
        three_phase_step <= s[3];
        repeat (3) @(posedge hclk);
        check(32'(step_duty_code), ((s[3] ? w : v) >> (28 - 3 * (s % 8))) & 32'h7);
      end
      check(32'(wide_mod_angle_advance), 32'(w[6:5]) * 32'h5);
      bus(1'b0, ssdp_pkg::STATUS_ADDR, {8'h00, 4'(w[6:5] * 5), w[9:7], TBL[w[9:7]], 3'h0});
      $display("profile pass done");
    end
    stop_test();
  end
endmodule : test_ssdp_regs
